// file: pkg/cbwd_regs.svh
// register indices, field positions, reset values and decode constants of the window decoder
`ifndef CBWD_REGS_SVH
`define CBWD_REGS_SVH

// register indices; byte address on the bus is four times the index, plus 100h for function 1
`define CBWD_IDX_SEC_BUS      6'h19
`define CBWD_IDX_SUB_BUS      6'h1A
`define CBWD_IDX_LAT_TMR      6'h1B
`define CBWD_IDX_MEM0_BASE    6'h1C
`define CBWD_IDX_MEM0_LIMIT   6'h20
`define CBWD_IDX_MEM1_BASE    6'h24
`define CBWD_IDX_MEM1_LIMIT   6'h28
`define CBWD_IDX_IO0_BASE     6'h2C
`define CBWD_IDX_IO1_BASE     6'h34

// byte address layout: [7:2] index, [8] socket function
`define CBWD_ADDR_IDX_LSB     2
`define CBWD_ADDR_IDX_MSB     7
`define CBWD_ADDR_FN_BIT      8

// writable field positions
`define CBWD_MEM_LSB          12
`define CBWD_MEM_MSB          31
`define CBWD_IO_LSB           2
`define CBWD_IO_MSB           15

// reset values
`define CBWD_RST_BYTE         8'h00
`define CBWD_RST_MEM          20'h00000
`define CBWD_RST_IO           14'h0000
`define CBWD_RST_WORD         32'h00000000

// number of socket functions and memory windows per function
`define CBWD_NUM_FN           2
`define CBWD_NUM_WIN          2

`endif

// file: pkg/cbwd_pkg.sv
// types shared by the window decoder files
package cbwd_pkg;

  // per socket function register copy
  typedef struct packed {
    logic [7:0]       sec_bus;
    logic [7:0]       sub_bus;
    logic [7:0]       lat_tmr;
    logic [1:0][19:0] mem_base;
    logic [1:0][19:0] mem_limit;
    logic [1:0][13:0] io_base;
  } cbwd_fn_regs_t;

  // latency timer phase of one function's initiator
  typedef enum logic [1:0] {
    CBWD_LT_IDLE,
    CBWD_LT_COUNT,
    CBWD_LT_EXPIRED
  } cbwd_lat_state_t;

endpackage : cbwd_pkg

// file: core/cbwd_win_match.sv
// compares one address against one memory base/limit window
`timescale 1ns/10ps
`include "cbwd_regs.svh"

module cbwd_win_match (
  input  wire logic [19:0] base_i,
  input  wire logic [19:0] limit_i,
  input  wire logic [31:0] addr_i,
  output logic             enable_o,
  output logic             hit_o
);

  // =====================================================================
  // window compare
  // a window with base and limit both zero stays closed, so the low 4K
  // page is not passed downstream after reset
  assign enable_o = (base_i != `CBWD_RST_MEM) || (limit_i != `CBWD_RST_MEM); // [RQ13]
  // limit low 12 bits count as ones, so comparing page numbers is exact
  assign hit_o    = enable_o
                    && (addr_i[`CBWD_MEM_MSB:`CBWD_MEM_LSB] >= base_i)    // [RQ19]
                    && (addr_i[`CBWD_MEM_MSB:`CBWD_MEM_LSB] <= limit_i);  // [RQ15]

endmodule : cbwd_win_match

// file: core/cbwd_bridge_decode.sv
// socket configuration registers, bus number, memory window and latency decode
// How it works
// RQ1: secondary bus number register, 8 bits read/write, resets to zero.
// RQ2: forward configuration cycles by comparing target with primary, secondary, subordinate.
// RQ3: subordinate bus number register, 8 bits read/write, resets to zero.
// RQ4: each socket function keeps its own bus number copies.
// RQ5: latency timer register, 8 bits read/write, counts clock cycles.
// RQ6: timer loads programmed value when our initiator asserts frame.
// RQ7: expired timer ends our transaction at the next completed data phase.
// RQ8: software should program the latency timer to at least 20h.
// RQ9: two memory base registers, bits 31 to 12 writable.
// RQ10: memory base and limit bits 11 to 0 read zero, writes ignored.
// RQ11: two memory limit registers, bits 31 to 12 writable, reset zero.
// RQ12: host cycles inside a window go down; card cycles outside go up.
// RQ13: a window claims only when its base or limit is nonzero.
// RQ14: windows 0 and 1 prefetchable per bridge control bits 8 and 9.
// RQ15: limit registers give each window's upper bound.
// RQ16: I/O base bits 31 to 16 and 1 to 0 read zero.
// RQ17: I/O base low 16 bits mark the window bottom.
// RQ18: I/O window passes only when its base or limit is nonzero.
// RQ19: address hits when base <= address <= limit with limit low bits ones.
// RQ20: reset clears every register, timer and window.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "cbwd_regs.svh"

module cbwd_bridge_decode
  import cbwd_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // configuration cycle decode
  input  wire logic        cfg_valid_i,
  input  wire logic        cfg_fn_i,
  input  wire logic [7:0]  cfg_bus_i,
  input  wire logic [7:0]  pri_bus_i,
  output logic             cfg_fwd_o,
  output logic             cfg_local_seg_o,
  // host memory request decode
  input  wire logic        mem_valid_i,
  input  wire logic        mem_fn_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [3:0]  prefetch_ctl_i,
  output logic             mem_claim_o,
  output logic             mem_window_o,
  output logic             mem_prefetch_o,
  // card originated memory request decode
  input  wire logic        cb_valid_i,
  input  wire logic        cb_fn_i,
  input  wire logic [31:0] cb_addr_i,
  output logic             cb_to_host_o,
  // i/o window enables, limit side supplied by its own logic
  input  wire logic [3:0]  io_limit_nz_i,
  output logic [3:0]       io_window_en_o,
  // card initiator latency control, one bit per function
  input  wire logic [1:0]  frame_start_i,
  input  wire logic [1:0]  phase_done_i,
  input  wire logic [1:0]  xact_end_i,
  output logic [1:0]       lat_stop_o
);

  // =====================================================================
  // state
  // every flop of the block sits in this struct; the next-state process
  // starts from a full copy, so any field it leaves alone simply holds
  // its value and no latch can form
  typedef struct packed {
    cbwd_fn_regs_t [1:0]   fn;
    logic [1:0][7:0]       lat_cnt;
    cbwd_lat_state_t [1:0] lat_st;
    logic [31:0]           rdata;
    logic                  cfg_fwd;
    logic                  cfg_local;
    logic                  mem_claim;
    logic                  mem_window;
    logic                  mem_prefetch;
    logic                  cb_to_host;
    logic [3:0]            io_en;
    logic [1:0]            lat_stop;
  } cbwd_state_t;

  cbwd_state_t st;
  cbwd_state_t next_st;

  // =====================================================================
  // bus decode
  // byte address: [8] picks the socket function, [7:2] the register
  // index; every other bit must be clear or the access is refused, so
  // aliases of the register block never answer
  logic [5:0] acc_idx;
  logic       acc_fn;
  logic       acc_mapped;
  logic       acc_wr;
  logic       acc_setup;

  assign acc_idx   = paddr_i[`CBWD_ADDR_IDX_MSB:`CBWD_ADDR_IDX_LSB];
  assign acc_fn    = paddr_i[`CBWD_ADDR_FN_BIT];
  assign acc_setup = psel_i && !penable_i;
  assign acc_wr    = psel_i && penable_i && pwrite_i && acc_mapped;

  // only listed indices answer; upper address bits must be clear
  // a hole in the index map reads zero and flags an error
  always_comb begin
    unique case (acc_idx)
      `CBWD_IDX_SEC_BUS,
      `CBWD_IDX_SUB_BUS,
      `CBWD_IDX_LAT_TMR,
      `CBWD_IDX_MEM0_BASE,
      `CBWD_IDX_MEM0_LIMIT,
      `CBWD_IDX_MEM1_BASE,
      `CBWD_IDX_MEM1_LIMIT,
      `CBWD_IDX_IO0_BASE,
      `CBWD_IDX_IO1_BASE: acc_mapped = (paddr_i[31:9] == 23'h000000)
                                       && (paddr_i[1:0] == 2'h0);
      default:            acc_mapped = 1'b0;
    endcase
  end

  // the slave never stalls; an unmapped access ends with an error
  // zero wait states cost a read capture in the setup cycle, which is why
  // prdata comes from a flop loaded one cycle before the access phase
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !acc_mapped;
  assign prdata_o  = st.rdata;

  // byte lane merge of a write into the old word
  // limitation: only lanes with a strobe set are written; an all-zero
  // strobe makes the write a no-op
  function automatic logic [31:0] cbwd_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : cbwd_merge

  // =====================================================================
  // register read view of the addressed function
  // read-only bits are rebuilt as zeros here rather than stored, so no
  // write can ever disturb them
  logic [31:0] rd_word;
  cbwd_fn_regs_t rd_fn;

  assign rd_fn = st.fn[acc_fn]; // each function answers from its own copy [RQ4]

  always_comb begin
    rd_word = `CBWD_RST_WORD;
    unique case (acc_idx)
      `CBWD_IDX_SEC_BUS:    rd_word = {24'h000000, rd_fn.sec_bus};
      `CBWD_IDX_SUB_BUS:    rd_word = {24'h000000, rd_fn.sub_bus};
      `CBWD_IDX_LAT_TMR:    rd_word = {24'h000000, rd_fn.lat_tmr};
      // low 12 bits of memory windows always read zero [RQ10]
      `CBWD_IDX_MEM0_BASE:  rd_word = {rd_fn.mem_base[0], 12'h000};
      `CBWD_IDX_MEM0_LIMIT: rd_word = {rd_fn.mem_limit[0], 12'h000};
      `CBWD_IDX_MEM1_BASE:  rd_word = {rd_fn.mem_base[1], 12'h000};
      `CBWD_IDX_MEM1_LIMIT: rd_word = {rd_fn.mem_limit[1], 12'h000};
      // i/o base pinned to the first 64K page, dword aligned [RQ16]
      `CBWD_IDX_IO0_BASE:   rd_word = {16'h0000, rd_fn.io_base[0], 2'h0};
      `CBWD_IDX_IO1_BASE:   rd_word = {16'h0000, rd_fn.io_base[1], 2'h0};
      default:              rd_word = `CBWD_RST_WORD;
    endcase
  end

  // =====================================================================
  // window matching, one set per function and window
  // host and card paths get their own comparators; sharing one would
  // need an arbiter and would stall one side every time both are busy
  logic [1:0][1:0] host_hit;
  logic [1:0][1:0] card_hit;

  for (genvar f = 0; f < `CBWD_NUM_FN; f++) begin : g_fn
    for (genvar w = 0; w < `CBWD_NUM_WIN; w++) begin : g_win
      // host side request against this window
      cbwd_win_match u_host (
        .base_i   (st.fn[f].mem_base[w]),
        .limit_i  (st.fn[f].mem_limit[w]),
        .addr_i   (mem_addr_i),
        .enable_o (),
        .hit_o    (host_hit[f][w])
      );
      // card side request against the same window
      cbwd_win_match u_card (
        .base_i   (st.fn[f].mem_base[w]),
        .limit_i  (st.fn[f].mem_limit[w]),
        .addr_i   (cb_addr_i),
        .enable_o (),
        .hit_o    (card_hit[f][w])
      );
    end
  end

  // =====================================================================
  // next state
  logic [1:0] sel_hit;
  logic [7:0] cfg_sec;
  logic [7:0] cfg_sub;
  logic [31:0] new_w;

  assign sel_hit = host_hit[mem_fn_i];
  assign cfg_sec = st.fn[cfg_fn_i].sec_bus;
  assign cfg_sub = st.fn[cfg_fn_i].sub_bus;

  always_comb begin
    next_st = st;
    // byte strobes merge into the current word, so a partial write keeps
    // the lanes it does not touch
    new_w   = cbwd_merge(rd_word, pwdata_i, pstrb_i);

    // read data is captured in the setup cycle, so it is steady in access
    if (acc_setup) begin
      next_st.rdata = acc_mapped ? rd_word : `CBWD_RST_WORD;
    end

    // writes land only in the addressed function's copy [RQ4]
    if (acc_wr) begin
      unique case (acc_idx)
        `CBWD_IDX_SEC_BUS:    next_st.fn[acc_fn].sec_bus = new_w[7:0]; // [RQ1]
        `CBWD_IDX_SUB_BUS:    next_st.fn[acc_fn].sub_bus = new_w[7:0]; // [RQ3]
        `CBWD_IDX_LAT_TMR:    next_st.fn[acc_fn].lat_tmr = new_w[7:0]; // [RQ5]
        // only the page number is kept; writes to bits 11..0 vanish [RQ10]
        `CBWD_IDX_MEM0_BASE:
          next_st.fn[acc_fn].mem_base[0] = new_w[`CBWD_MEM_MSB:`CBWD_MEM_LSB]; // [RQ9]
        `CBWD_IDX_MEM1_BASE:
          next_st.fn[acc_fn].mem_base[1] = new_w[`CBWD_MEM_MSB:`CBWD_MEM_LSB]; // [RQ9]
        `CBWD_IDX_MEM0_LIMIT:
          next_st.fn[acc_fn].mem_limit[0] = new_w[`CBWD_MEM_MSB:`CBWD_MEM_LSB]; // [RQ11]
        `CBWD_IDX_MEM1_LIMIT:
          next_st.fn[acc_fn].mem_limit[1] = new_w[`CBWD_MEM_MSB:`CBWD_MEM_LSB]; // [RQ11]
        `CBWD_IDX_IO0_BASE:
          next_st.fn[acc_fn].io_base[0] = new_w[`CBWD_IO_MSB:`CBWD_IO_LSB]; // [RQ17]
        `CBWD_IDX_IO1_BASE:
          next_st.fn[acc_fn].io_base[1] = new_w[`CBWD_IO_MSB:`CBWD_IO_LSB]; // [RQ17]
        default:              next_st.rdata = st.rdata;
      endcase
    end

    // configuration forward: within secondary..subordinate, not primary
    // a target on the primary bus stays local even if software has set up
    // an overlapping secondary range; the cycle type follows the local flag
    next_st.cfg_fwd = cfg_valid_i
                      && (cfg_bus_i != pri_bus_i)
                      && (cfg_bus_i >= cfg_sec)
                      && (cfg_bus_i <= cfg_sub); // [RQ2]
    // the card segment itself takes a type 0 cycle
    next_st.cfg_local = cfg_valid_i
                        && (cfg_bus_i != pri_bus_i)
                        && (cfg_bus_i == cfg_sec); // [RQ2]

    // host memory claim; window 0 wins if both overlap
    // overlap is a software fault; a fixed priority keeps the answer
    // deterministic instead of claiming through two windows at once
    next_st.mem_claim    = mem_valid_i && (sel_hit != 2'h0); // [RQ12]
    next_st.mem_window   = !sel_hit[0];
    // prefetch control bits per function: [1:0] fn0, [3:2] fn1 [RQ14]
    next_st.mem_prefetch = mem_valid_i && (sel_hit != 2'h0)
                           && prefetch_ctl_i[{mem_fn_i, !sel_hit[0]}];

    // card cycles aimed outside its own windows head upstream [RQ12]
    // a card address inside a window belongs to the card segment itself
    next_st.cb_to_host = cb_valid_i && (card_hit[cb_fn_i] == 2'h0);

    // i/o windows open once base or limit is nonzero [RQ18]
    // the limit registers live elsewhere; only their nonzero flags come in
    for (int f = 0; f < `CBWD_NUM_FN; f++) begin
      for (int w = 0; w < `CBWD_NUM_WIN; w++) begin
        next_st.io_en[2*f + w] = (st.fn[f].io_base[w] != `CBWD_RST_IO)
                                 || io_limit_nz_i[2*f + w];
      end
    end

    // latency timer per function; a short programmed value cuts bursts early,
    // so software keeps it at 20h or more [RQ8]
    // a programmed zero means the timer is already expired at frame start,
    // so the transaction ends after its first data phase
    // each function owns its timer, so both sockets can burst at once
    for (int f = 0; f < `CBWD_NUM_FN; f++) begin
      unique case (st.lat_st[f])
        CBWD_LT_IDLE: begin
          if (frame_start_i[f]) begin
            next_st.lat_cnt[f] = st.fn[f].lat_tmr; // [RQ6]
            next_st.lat_st[f]  = (st.fn[f].lat_tmr == `CBWD_RST_BYTE) ?
                                 CBWD_LT_EXPIRED : CBWD_LT_COUNT;
          end
        end
        // the count runs L..1; a transaction that ends first leaves quietly
        CBWD_LT_COUNT: begin
          if (xact_end_i[f]) begin
            next_st.lat_st[f] = CBWD_LT_IDLE;
          end else if (st.lat_cnt[f] == 8'h01) begin
            next_st.lat_cnt[f] = 8'h00;
            next_st.lat_st[f]  = CBWD_LT_EXPIRED; // [RQ5]
          end else begin
            next_st.lat_cnt[f] = st.lat_cnt[f] - 8'h01;
          end
        end
        CBWD_LT_EXPIRED: begin
          // the stop applies to the data phase now under way [RQ7]
          if (xact_end_i[f] || phase_done_i[f]) begin
            next_st.lat_st[f] = CBWD_LT_IDLE;
          end
        end
        default: next_st.lat_st[f] = CBWD_LT_IDLE;
      endcase
      next_st.lat_stop[f] = (next_st.lat_st[f] == CBWD_LT_EXPIRED); // [RQ7]
    end
  end

  // =====================================================================
  // state register; reset clears every window, timer and bus number
  // the reset branch loads constants only, so the flops reset without a
  // path through the next-state logic
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0; // [RQ20]
    end else begin
      st <= next_st;
    end
  end

  // =====================================================================
  // outputs
  // all decode results leave from flops, one cycle after the request;
  // the requester must hold off acting on them until that cycle
  assign cfg_fwd_o       = st.cfg_fwd;
  assign cfg_local_seg_o = st.cfg_local;
  assign mem_claim_o     = st.mem_claim;
  assign mem_window_o    = st.mem_window;
  assign mem_prefetch_o  = st.mem_prefetch;
  assign cb_to_host_o    = st.cb_to_host;
  assign io_window_en_o  = st.io_en;
  assign lat_stop_o      = st.lat_stop;

endmodule : cbwd_bridge_decode

// file: verification/cbwd_card_model.sv
// card side initiator model: raises frame, completes data phases, ends on stop
`timescale 1ns/10ps

module cbwd_card_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       go_i,
  input  wire logic       fn_i,
  input  wire logic       slow_i,
  input  wire logic [1:0] lat_stop_i,
  output logic [1:0]      frame_start_o,
  output logic [1:0]      phase_done_o,
  output logic [1:0]      xact_end_o
);
  logic       busy;
  logic [1:0] ph;

  // ===========================================
  // one transaction at a time; slow mode finishes a phase every fourth cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy          <= 1'h0;
      ph            <= 2'h0;
      frame_start_o <= 2'h0;
      phase_done_o  <= 2'h0;
      xact_end_o    <= 2'h0;
    end else begin
      frame_start_o <= 2'h0;
      phase_done_o  <= 2'h0;
      xact_end_o    <= 2'h0;
      if (go_i && !busy) begin
        busy              <= 1'h1;
        ph                <= 2'h0;
        frame_start_o[fn_i] <= 1'h1;
      end else if (busy) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3 || !slow_i) begin
          phase_done_o[fn_i] <= 1'h1;
          // a stop is honoured only at a completed phase
          if (lat_stop_i[fn_i]) begin
            xact_end_o[fn_i] <= 1'h1;
            busy             <= 1'h0;
          end
        end
      end
    end
  end
endmodule : cbwd_card_model

// file: verification/cbwd_bridge_decode_sva.sv
// port checker for the window decoder
`timescale 1ns/10ps

module cbwd_bridge_decode_sva (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        cfg_valid_i,
  input wire logic [7:0]  cfg_bus_i,
  input wire logic [7:0]  pri_bus_i,
  input wire logic        cfg_fwd_o,
  input wire logic        mem_valid_i,
  input wire logic        mem_fn_i,
  input wire logic [3:0]  prefetch_ctl_i,
  input wire logic        mem_claim_o,
  input wire logic        mem_window_o,
  input wire logic        mem_prefetch_o,
  input wire logic        cb_valid_i,
  input wire logic        cb_to_host_o,
  input wire logic [3:0]  io_limit_nz_i,
  input wire logic [3:0]  io_window_en_o,
  input wire logic [1:0]  phase_done_i,
  input wire logic [1:0]  xact_end_i,
  input wire logic [1:0]  lat_stop_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic       up_q;
  logic       fn_q;
  logic [3:0] pf_q;

  // ===========================================
  // sampled copies so prefetch is judged against the request's own cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_q <= 1'h0;
      fn_q <= 1'h0;
      pf_q <= 4'h0;
    end else begin
      up_q <= 1'h1;
      fn_q <= mem_fn_i;
      pf_q <= prefetch_ctl_i;
    end
  end

  AST_PRI_NOFWD: assert property (cfg_valid_i && cfg_bus_i == pri_bus_i |=> !cfg_fwd_o)
    else $error("primary bus target forwarded");
  AST_FWD_CAUSE: assert property (cfg_fwd_o |-> $past(cfg_valid_i))
    else $error("forward without a request");
  AST_CLAIM_CAUSE: assert property (mem_claim_o |-> $past(mem_valid_i))
    else $error("claim without a request");
  AST_NOCLAIM_IDLE: assert property (!mem_valid_i |=> !mem_claim_o)
    else $error("claim while idle");
  AST_PREFETCH: assert property (mem_claim_o |->
      mem_prefetch_o == pf_q[{fn_q, mem_window_o}])
    else $error("prefetch does not follow control bit");
  AST_UP_CAUSE: assert property (cb_to_host_o |-> $past(cb_valid_i))
    else $error("upstream without a request");
  AST_IO_EN: assert property (up_q && |io_limit_nz_i |=>
      (io_window_en_o & $past(io_limit_nz_i)) == $past(io_limit_nz_i))
    else $error("io window not enabled by limit");
  AST_LAT_DROP: assert property (lat_stop_o[0] && phase_done_i[0] |=> !lat_stop_o[0])
    else $error("stop kept after data phase");
  AST_LAT_HOLD: assert property (lat_stop_o[0] && !phase_done_i[0] && !xact_end_i[0]
      |=> lat_stop_o[0])
    else $error("stop dropped early");
endmodule : cbwd_bridge_decode_sva

bind cbwd_bridge_decode cbwd_bridge_decode_sva sva_u (.*);

// file: verification/test_cbwd_bridge_decode.sv
// self-checking bench for the window decoder
`timescale 1ns/10ps
`include "cbwd_regs.svh"

module test_cbwd_bridge_decode;
  logic        clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, mem_addr = 32'h0;
  logic        pready, pslverr, er, cfg_valid = 1'h0, cfg_fn = 1'h0, fwd, lseg;
  logic [7:0]  cfg_bus = 8'h0, pri_bus = 8'h06;
  logic        mem_valid = 1'h0, mem_fn = 1'h0, claim, win, pref, to_host;
  logic [3:0]  pf_ctl = 4'h2, io_nz = 4'h0, io_en;
  logic        go = 1'h0, slow = 1'h0;
  logic [1:0]  fs, pd, xe, lstop;
  int          bad_count = 0, samples_checked = 0;

  always #50 clk = ~clk;

  cbwd_bridge_decode dut_u (.ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cfg_valid_i(cfg_valid), .cfg_fn_i(cfg_fn), .cfg_bus_i(cfg_bus), .pri_bus_i(pri_bus),
    .cfg_fwd_o(fwd), .cfg_local_seg_o(lseg), .mem_valid_i(mem_valid), .mem_fn_i(mem_fn),
    .mem_addr_i(mem_addr), .prefetch_ctl_i(pf_ctl), .mem_claim_o(claim),
    .mem_window_o(win), .mem_prefetch_o(pref), .cb_valid_i(mem_valid), .cb_fn_i(mem_fn),
    .cb_addr_i(mem_addr), .cb_to_host_o(to_host), .io_limit_nz_i(io_nz),
    .io_window_en_o(io_en), .frame_start_i(fs), .phase_done_i(pd), .xact_end_i(xe),
    .lat_stop_o(lstop));
  cbwd_card_model card_u (.ref_clk_i(clk), .rst_b_i(rst_b), .go_i(go), .fn_i(1'h0),
    .slow_i(slow), .lat_stop_i(lstop), .frame_start_o(fs), .phase_done_o(pd),
    .xact_end_o(xe));

  // ===========================================
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // a wait that ran out of cycles is a mismatch and ends the run
  task automatic tmo(input logic ok);
    if (ok !== 1'h1) begin
      bad_count++;
      $display("[ERR] wait expected 1 seen %b", ok);
      final_report();
    end
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] ad(input logic f, input logic [5:0] i);
    return {23'h0, f, i, 2'h0};
  endfunction : ad

  // apb transfer: held until pready is sampled high, answer taken at that edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'h1 && n < 20);
    tmo(pready === 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rchk(input string nm, input logic f, input logic [5:0] i,
                      input logic [31:0] exp);
    apb(1'h0, ad(f, i), 32'h0);
    chk(nm, exp, rd);
  endtask : rchk

  // ===========================================
  task automatic t_reset;
    logic [5:0] idx [9] = '{`CBWD_IDX_SEC_BUS, `CBWD_IDX_SUB_BUS, `CBWD_IDX_LAT_TMR,
      `CBWD_IDX_MEM0_BASE, `CBWD_IDX_MEM0_LIMIT, `CBWD_IDX_MEM1_BASE,
      `CBWD_IDX_MEM1_LIMIT, `CBWD_IDX_IO0_BASE, `CBWD_IDX_IO1_BASE};
    for (int f = 0; f < 2; f++) foreach (idx[k]) rchk("reset", f[0], idx[k], 32'h0);
    @(posedge clk) mem_valid <= 1'h1;
    @(posedge clk) mem_valid <= 1'h0;
    @(negedge clk);
    chk("idle window", 32'h1, {claim, to_host});
    chk("io idle", 32'h0, io_en);
  endtask : t_reset

  task automatic t_regs;
    apb(1'h1, ad(0, `CBWD_IDX_SEC_BUS), 32'h05);
    apb(1'h1, ad(1, `CBWD_IDX_SEC_BUS), 32'hA5);
    apb(1'h1, ad(0, `CBWD_IDX_SUB_BUS), 32'h08);
    apb(1'h1, ad(1, `CBWD_IDX_SUB_BUS), 32'hC0);
    apb(1'h1, ad(1, `CBWD_IDX_MEM0_BASE), 32'hFFFFFFFF);
    apb(1'h1, ad(1, `CBWD_IDX_MEM1_LIMIT), 32'hFFFFFFFF);
    apb(1'h1, ad(1, `CBWD_IDX_IO0_BASE), 32'hFFFFFFFF);
    rchk("sec f0", 0, `CBWD_IDX_SEC_BUS, 32'h05);
    rchk("sec f1", 1, `CBWD_IDX_SEC_BUS, 32'hA5);
    rchk("sub f0", 0, `CBWD_IDX_SUB_BUS, 32'h08);
    rchk("sub f1", 1, `CBWD_IDX_SUB_BUS, 32'hC0);
    rchk("mem base", 1, `CBWD_IDX_MEM0_BASE, 32'hFFFFF000);
    rchk("mem limit", 1, `CBWD_IDX_MEM1_LIMIT, 32'hFFFFF000);
    rchk("io base", 1, `CBWD_IDX_IO0_BASE, 32'h0000FFFC);
    apb(1'h0, 32'h0000003C, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, er);
  endtask : t_regs

  task automatic t_cfg;
    logic [10:0] tb [6] = '{{1'h0, 8'h06, 2'h0}, {1'h0, 8'h04, 2'h0}, {1'h0, 8'h05, 2'h3},
                            {1'h0, 8'h08, 2'h2}, {1'h0, 8'h09, 2'h0}, {1'h1, 8'h05, 2'h0}};
    foreach (tb[k]) begin
      @(posedge clk) {cfg_valid, cfg_fn, cfg_bus} <= {1'h1, tb[k][10:2]};
      @(posedge clk) cfg_valid <= 1'h0;
      @(negedge clk);
      chk("cfg forward", tb[k][1:0], {fwd, lseg});
    end
  endtask : t_cfg

  task automatic t_mem;
    logic [35:0] tb [5] = '{{32'h0FFFFFFC, 4'h1}, {32'h10000000, 4'h8},
      {32'h10000FFC, 4'h8}, {32'h10001000, 4'h1}, {32'h20001FFC, 4'hE}};
    apb(1'h1, ad(0, `CBWD_IDX_MEM0_BASE), 32'h10000ABC);
    apb(1'h1, ad(0, `CBWD_IDX_MEM0_LIMIT), 32'h10000000);
    apb(1'h1, ad(0, `CBWD_IDX_MEM1_BASE), 32'h20000000);
    apb(1'h1, ad(0, `CBWD_IDX_MEM1_LIMIT), 32'h20001000);
    foreach (tb[k]) begin
      @(posedge clk) {mem_valid, mem_addr} <= {1'h1, tb[k][35:4]};
      @(posedge clk) mem_valid <= 1'h0;
      @(negedge clk);
      chk("mem", tb[k][3:0], {claim, claim&win, claim&pref, to_host});
    end
  endtask : t_mem

  task automatic t_io;
    apb(1'h1, ad(0, `CBWD_IDX_IO0_BASE), 32'h00001000);
    @(posedge clk) io_nz <= 4'h8;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("io enable", 32'hD, io_en);
  endtask : t_io

  // latency count from the frame edge, then the stop held until a phase completes
  task automatic t_lat(input logic [7:0] l);
    int n;
    apb(1'h1, ad(0, `CBWD_IDX_LAT_TMR), {24'h0, l});
    slow <= l[5];
    @(posedge clk) go <= 1'h1;
    n = 0;
    do begin @(posedge clk); n++; end while (fs[0] !== 1'h1 && n < 20);
    tmo(fs[0] === 1'h1);
    go <= 1'h0;
    n = 0;
    do begin @(negedge clk); n++; end while (lstop[0] !== 1'h1 && n < 300);
    tmo(lstop[0] === 1'h1);
    // stop shows in the cycle after the timer loaded and ran L cycles
    chk("lat count", {24'h0, l} + 32'h1, n);
    n = 0;
    do begin @(negedge clk); n++; end while (lstop[0] !== 1'h0 && n < 20);
    tmo(lstop[0] === 1'h0);
    chk("lat stop end", 32'h0, {lstop[0], n > 6});
    repeat (4) @(posedge clk);
  endtask : t_lat

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    t_reset();
    t_regs();
    t_cfg();
    t_mem();
    t_io();
    t_lat(8'h20);
    t_lat(8'h00);
    final_report();
  end
endmodule : test_cbwd_bridge_decode
